/* design/hpc_pkg.sv */
/*
  Constants, field layouts and carrier types for the hibernation power control block.
  Assumes a single 250 MHz system clock and a plain strobe register port.
*/
package hpc_pkg;

  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NSRC   = 4;

  // register offsets (byte addresses)
  localparam logic [8:0] OFF_RTC    = 9'h000;
  localparam logic [8:0] OFF_MATCH0 = 9'h004;
  localparam logic [8:0] OFF_MATCH1 = 9'h008;
  localparam logic [8:0] OFF_CTRL   = 9'h00c;
  localparam logic [8:0] OFF_IM     = 9'h010;
  localparam logic [8:0] OFF_RIS    = 9'h014;
  localparam logic [8:0] OFF_MIS    = 9'h018;
  localparam logic [8:0] OFF_IC     = 9'h01c;
  localparam logic [8:0] OFF_DATA   = 9'h100;
  localparam int unsigned DATA_WORDS = 64;

  // source bit positions, shared by mask, status and clear
  localparam int unsigned SRC_PIN_WAKE    = 0;
  localparam int unsigned SRC_LOW_BATTERY = 1;
  localparam int unsigned SRC_MATCH0      = 2;
  localparam int unsigned SRC_MATCH1      = 3;
  localparam int unsigned low_battery_irq_bit = SRC_LOW_BATTERY;

  // control register: write-only request bit above the stored fields
  localparam int unsigned CTRL_REQ_BIT = 7;
  localparam logic [6:0]  CTRL_RESET   = 7'h00;

  // clock source figures
  localparam int unsigned XTAL_DIV   = 128;
  localparam int unsigned RTC_PREDIV = 32768;

  // pin sampling vector positions
  localparam int unsigned PIN_WAKE = 0;
  localparam int unsigned PIN_LOWB = 1;
  localparam int unsigned PIN_OSC  = 2;
  localparam int unsigned PIN_XTAL = 3;

  typedef struct packed {
    logic low_battery_abort_mode;       // bit 6
    logic low_battery_detect_mode;      // bit 5
    logic wake_rtc_en;                  // bit 4
    logic wake_pin_en;                  // bit 3
    logic crystal_divided_clock_select; // bit 2
    logic rtc_en;                       // bit 1
    logic active;                       // bit 0
  } hpc_ctrl_s;

  typedef enum logic [1:0] {
    HPC_RUN = 2'b01,
    HPC_HIB = 2'b10
  } hpc_state_e;

endpackage

/* design/hpc_top.sv */
/*
  Hibernation power control: interrupt status and mask, counter with two
  match registers, low battery handling, regulator enable sequencing and
  retained storage. Assumes the pins wake_pin, battery_low, osc_in and xtal_in
  are asynchronous; rst is the cold reset of the battery-backed domain only.
*/
// Local design decisions: the placing of the registers and the strobed register port.
module hpc_top #(
  parameter int unsigned PREDIV = hpc_pkg::RTC_PREDIV
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst,
  // register port
  input  wire logic [hpc_pkg::ADDR_W-1:0] addr,
  input  wire logic [hpc_pkg::DATA_W-1:0] wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [hpc_pkg::DATA_W-1:0] rdata,
  // external pins
  input  wire logic                      wake_pin,
  input  wire logic                      battery_low,
  input  wire logic                      osc_in,
  input  wire logic                      xtal_in,
  output logic                           regulator_en,
  output logic                           irq
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, level moves once stages two and three agree
  logic [3:0] s1_q, s2_q, s3_q, pin_q, pin_d, pin_prev_q;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : pin_q[i];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q       <= 4'h0;
      s2_q       <= 4'h0;
      s3_q       <= 4'h0;
      pin_q      <= 4'h0;
      pin_prev_q <= 4'h0;
    end else begin
      s1_q       <= {xtal_in, osc_in, battery_low, wake_pin};
      s2_q       <= s1_q;
      s3_q       <= s2_q;
      pin_q      <= pin_d;
      pin_prev_q <= pin_q;
    end
  end

  logic [3:0] pin_rise;
  assign pin_rise = pin_q & ~pin_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  logic ctrl_wr, ic_wr, rtc_wr, m0_wr, m1_wr, im_wr, data_hit;
  assign ctrl_wr  = wr && (addr == hpc_pkg::OFF_CTRL);
  assign ic_wr    = wr && (addr == hpc_pkg::OFF_IC);
  assign rtc_wr   = wr && (addr == hpc_pkg::OFF_RTC);
  assign m0_wr    = wr && (addr == hpc_pkg::OFF_MATCH0);
  assign m1_wr    = wr && (addr == hpc_pkg::OFF_MATCH1);
  assign im_wr    = wr && (addr == hpc_pkg::OFF_IM);
  assign data_hit = addr[8] && (addr[1:0] == 2'b00);

  ////////////////////////////////////////////////////////////////////////////
  // counter clock: raw oscillator edge or every 128th crystal edge, then predivider
  hpc_pkg::hpc_ctrl_s ctrl_q, ctrl_d;
  logic [6:0]  xdiv_q, xdiv_d;
  logic [15:0] pre_q, pre_d;
  logic [31:0] rtc_q, rtc_d, match0_q, match0_d, match1_q, match1_d;
  logic        src_tick, sec_tick, rtc_run, ev_m0, ev_m1;

  assign rtc_run = ctrl_q.active && ctrl_q.rtc_en;

  always_comb begin
    xdiv_d   = xdiv_q;
    src_tick = 1'b0;
    if (ctrl_q.crystal_divided_clock_select) begin
      if (pin_rise[hpc_pkg::PIN_XTAL]) begin
        xdiv_d   = 7'(xdiv_q + 7'h01);
        src_tick = (xdiv_q == 7'(hpc_pkg::XTAL_DIV - 1));
      end
    end else begin
      src_tick = pin_rise[hpc_pkg::PIN_OSC];
    end
    pre_d    = pre_q;
    sec_tick = 1'b0;
    if (rtc_run && src_tick) begin
      if (pre_q == 16'(PREDIV - 1)) begin
        pre_d    = 16'h0000;
        sec_tick = 1'b1;
      end else begin
        pre_d = 16'(pre_q + 16'h0001);
      end
    end
    rtc_d    = rtc_q;
    match0_d = m0_wr ? wdata : match0_q;
    match1_d = m1_wr ? wdata : match1_q;
    if (rtc_wr) begin
      rtc_d = wdata;
      pre_d = 16'h0000;
    end else if (sec_tick) begin
      rtc_d = rtc_q + 32'h0000_0001;
    end
    // a match fires as the counter steps onto the match value
    ev_m0 = sec_tick && !rtc_wr && (rtc_d == match0_q);
    ev_m1 = sec_tick && !rtc_wr && (rtc_d == match1_q);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      xdiv_q   <= 7'h00;
      pre_q    <= 16'h0000;
      rtc_q    <= 32'h0000_0000;
      match0_q <= 32'h0000_0000;
      match1_q <= 32'h0000_0000;
    end else begin
      xdiv_q   <= xdiv_d;
      pre_q    <= pre_d;
      rtc_q    <= rtc_d;
      match0_q <= match0_d;
      match1_q <= match1_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: events set, clear writes drop, set beats clear
  logic [3:0] ris_q, ris_d, im_q, im_d, set_ev, mis;
  logic       irq_q, irq_d, lowbat_now;

  assign lowbat_now = pin_q[hpc_pkg::PIN_LOWB] && ctrl_q.active &&
                      (ctrl_q.low_battery_detect_mode || ctrl_q.low_battery_abort_mode);
  assign mis = ris_q & im_q;

  always_comb begin
    set_ev = 4'h0;
    set_ev[hpc_pkg::SRC_PIN_WAKE]        = pin_rise[hpc_pkg::PIN_WAKE] && ctrl_q.active;
    set_ev[hpc_pkg::low_battery_irq_bit] = lowbat_now;
    set_ev[hpc_pkg::SRC_MATCH0]          = ev_m0;
    set_ev[hpc_pkg::SRC_MATCH1]          = ev_m1;
    ris_d = ris_q;
    if (ic_wr) begin
      ris_d = ris_q & ~wdata[3:0];
    end
    ris_d = ris_d | set_ev;
    im_d  = im_wr ? wdata[3:0] : im_q;
    irq_d = |mis;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ris_q <= 4'h0;
      im_q  <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      ris_q <= ris_d;
      im_q  <= im_d;
      irq_q <= irq_d;
    end
  end

  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // control and power sequencing; survives processor reset, only rst clears it
  hpc_pkg::hpc_state_e state_q, state_d;
  logic req_take, wake_cond;

  assign req_take  = ctrl_wr && wdata[hpc_pkg::CTRL_REQ_BIT] && ctrl_d.active;
  assign wake_cond = (ctrl_q.wake_pin_en && pin_rise[hpc_pkg::PIN_WAKE]) ||
                     (ctrl_q.wake_rtc_en && (ev_m0 || ev_m1));

  always_comb begin
    ctrl_d  = ctrl_wr ? hpc_pkg::hpc_ctrl_s'(wdata[6:0]) : ctrl_q;
    state_d = state_q;
    case (state_q)
      hpc_pkg::HPC_RUN: begin
        // abort mode refuses the request while the battery reads low
        if (req_take && !(ctrl_d.low_battery_abort_mode && pin_q[hpc_pkg::PIN_LOWB])) begin
          state_d = hpc_pkg::HPC_HIB;
        end
      end
      hpc_pkg::HPC_HIB: begin
        if (wake_cond) begin
          state_d = hpc_pkg::HPC_RUN;
        end
      end
      default: state_d = hpc_pkg::HPC_RUN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl_q  <= hpc_pkg::hpc_ctrl_s'(hpc_pkg::CTRL_RESET);
      state_q <= hpc_pkg::HPC_RUN;
    end else begin
      ctrl_q  <= ctrl_d;
      state_q <= state_d;
    end
  end

  assign regulator_en = (state_q == hpc_pkg::HPC_RUN);

  ////////////////////////////////////////////////////////////////////////////
  // retained storage and read path; data stands one cycle after the read strobe
  logic [31:0] mem_q [hpc_pkg::DATA_WORDS];
  logic [31:0] rdata_q, rdata_d;

  always_ff @(posedge clock) begin
    if (wr && data_hit) begin
      mem_q[addr[7:2]] <= wdata;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd) begin
      if (data_hit) begin
        rdata_d = mem_q[addr[7:2]];
      end else begin
        case (addr)
          hpc_pkg::OFF_RTC:    rdata_d = rtc_q;
          hpc_pkg::OFF_MATCH0: rdata_d = match0_q;
          hpc_pkg::OFF_MATCH1: rdata_d = match1_q;
          hpc_pkg::OFF_CTRL:   rdata_d = {25'h0000000, ctrl_q};
          hpc_pkg::OFF_IM:     rdata_d = {28'h0000000, im_q};
          hpc_pkg::OFF_RIS:    rdata_d = {28'h0000000, ris_q};
          hpc_pkg::OFF_MIS:    rdata_d = {28'h0000000, mis};
          default:             rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_irq_follows_mis: assert property ((|mis) |=> irq)
    else $error("interrupt missing for pending enabled source");
  a_mask_blocks: assert property ((im_q == 4'h0) |=> !irq)
    else $error("interrupt with empty mask");
  a_set_wins: assert property ((|set_ev) |=> ((ris_q & $past(set_ev)) == $past(set_ev)))
    else $error("event lost in raw status");
  a_clear_drops: assert property (ic_wr && ((set_ev & wdata[3:0]) == 4'h0)
      |=> ((ris_q & $past(wdata[3:0])) == 4'h0))
    else $error("clear write left a bit pending");
  a_mis_read: assert property (rd && (addr == hpc_pkg::OFF_MIS)
      |=> (rdata == {28'h0000000, $past(mis)}))
    else $error("masked status read wrong");
  a_req_drops_reg: assert property (regulator_en && req_take && !pin_q[hpc_pkg::PIN_LOWB]
      |=> !regulator_en)
    else $error("regulator stayed on after request");
  a_abort_holds: assert property (req_take && ctrl_d.low_battery_abort_mode
      && pin_q[hpc_pkg::PIN_LOWB] && regulator_en |=> regulator_en)
    else $error("hibernation not aborted on low battery");
  a_wake_raises: assert property (!regulator_en && wake_cond |=> regulator_en)
    else $error("wake condition did not restore regulator");
  a_rtc_frozen: assert property (!rtc_run && !rtc_wr |=> $stable(rtc_q))
    else $error("counter moved while disabled");
  a_lowbat_flag: assert property (lowbat_now |=> ris_q[hpc_pkg::SRC_LOW_BATTERY])
    else $error("low battery not recorded");

  // readback and mask write checks: software sees the stored state one cycle after its strobe
  a_ctrl_readback: assert property (rd && (addr == hpc_pkg::OFF_CTRL)
      |=> (rdata == {25'h0000000, $past(ctrl_q)}))
    else $error("control read wrong");
  a_ris_readback: assert property (rd && (addr == hpc_pkg::OFF_RIS)
      |=> (rdata == {28'h0000000, $past(ris_q)}))
    else $error("raw status read wrong");
  a_rtc_readback: assert property (rd && (addr == hpc_pkg::OFF_RTC)
      |=> (rdata == $past(rtc_q)))
    else $error("counter read wrong");
  a_mask_write: assert property (im_wr
      |=> (im_q == $past(wdata[3:0])))
    else $error("mask write not stored");
  // counter and power checks: a count moves by one, and only a wake ends hibernation
  a_rtc_steps_one: assert property (sec_tick && !rtc_wr
      |=> (rtc_q == 32'($past(rtc_q) + 32'h0000_0001)))
    else $error("counter step wrong");
  a_hib_holds: assert property (!regulator_en && !wake_cond
      |=> !regulator_en)
    else $error("regulator returned without a wake");
  a_match_flags: assert property (ev_m1
      |=> ris_q[hpc_pkg::SRC_MATCH1])
    else $error("match one not recorded");
  a_pin_wakes: assert property (!regulator_en && ctrl_q.wake_pin_en
      && pin_rise[hpc_pkg::PIN_WAKE] |=> regulator_en)
    else $error("wake pin did not restore regulator");

endmodule

/* tb/hpc_far_side.sv */
/*
  Far side model: regulator load, battery comparator, wake pin and slow oscillator.
  Assumes the bench commands the pin levels and the system clock is 250 MHz.
*/
module hpc_far_side (
  // system clock
  input  wire logic clock,
  // levels commanded by the bench
  input  wire logic wake_lvl,
  input  wire logic batt_lvl,
  // pins toward the block
  input  wire logic regulator_en,
  output logic      wake_pin,
  output logic      battery_low,
  output logic      osc_in,
  output logic      xtal_in,
  output logic      powered
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] div_q = 4'h0;
  //////////////////////////////////////////////////////////////////////////////
  // free-running sources: oscillator period is 16 system cycles, crystal 4;
  // anything faster would never pass the block's three-stage pin filter
  always @(posedge clock) begin
    div_q <= div_q + 4'h1;
  end
  assign osc_in = div_q[3];
  assign xtal_in = div_q[1];
  // pins follow the bench; the load is powered while the regulator is on
  assign wake_pin = wake_lvl;
  assign battery_low = batt_lvl;
  assign powered = regulator_en;
endmodule

/* tb/hpc_top_test.sv */
/*
  Self-checking bench for the hibernation power control block.
  Assumes the block's strobe register port and a 250 MHz clock.
*/
module hpc_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock, rst, wr, rd, wake_lvl, batt_lvl;
  logic [8:0]  addr;
  logic [31:0] wdata, rdata, tmp;
  logic        regulator_en, irq, wake_pin, battery_low, osc_in, xtal_in, powered;
  int          error_cnt, compares, cycles, n;

  // counter predivider shortened so a tick is 64 cycles on the oscillator source
  hpc_top #(.PREDIV(4)) DUT (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .wake_pin(wake_pin), .battery_low(battery_low),
    .osc_in(osc_in), .xtal_in(xtal_in), .regulator_en(regulator_en), .irq(irq));
  hpc_far_side far (
    .clock(clock), .wake_lvl(wake_lvl), .batt_lvl(batt_lvl),
    .regulator_en(regulator_en), .wake_pin(wake_pin), .battery_low(battery_low),
    .osc_in(osc_in), .xtal_in(xtal_in), .powered(powered));
  //////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // bus and compare tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 tmp = rdata;
    check(tmp, exp);
  endtask
  // pins need several cycles through the synchronisers
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic stop_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 9'h000;
    wdata = 32'h0;
    wake_lvl = 1'b0;
    batt_lvl = 1'b0;
    error_cnt = 0;
    compares = 0;
    cycles = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    // cold start: inactive, regulator on, unmapped reads zero
    rd_chk(hpc_pkg::OFF_CTRL, 32'h0);
    check({31'h0, regulator_en}, 32'h1);
    rd_chk(9'h020, 32'h0);
    // pin wake with mask closed, then opened, then partial and full clear
    wr_reg(hpc_pkg::OFF_CTRL, 32'h09);
    wake_lvl <= 1'b1;
    wait_cyc(8);
    rd_chk(hpc_pkg::OFF_RIS, 32'h1);
    rd_chk(hpc_pkg::OFF_MIS, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr_reg(hpc_pkg::OFF_IM, 32'h1);
    wait_cyc(3);
    check({31'h0, irq}, 32'h1);
    rd_chk(hpc_pkg::OFF_MIS, 32'h1);
    wr_reg(hpc_pkg::OFF_IC, 32'he);
    wait_cyc(3);
    check({31'h0, irq}, 32'h1);
    rd_chk(hpc_pkg::OFF_RIS, 32'h1);
    @(posedge clock);
    wake_lvl <= 1'b0;
    wr_reg(hpc_pkg::OFF_IC, 32'h1);
    wait_cyc(3);
    check({31'h0, irq}, 32'h0);
    rd_chk(hpc_pkg::OFF_RIS, 32'h0);
    // low battery: detect sets status, abort refuses the request
    wr_reg(hpc_pkg::OFF_CTRL, 32'h21);
    batt_lvl <= 1'b1;
    wait_cyc(8);
    rd_chk(hpc_pkg::OFF_RIS, 32'h2);
    wr_reg(hpc_pkg::OFF_CTRL, 32'hc1);
    wait_cyc(2);
    check({31'h0, regulator_en}, 32'h1);
    rd_chk(hpc_pkg::OFF_CTRL, 32'h41);
    @(posedge clock);
    batt_lvl <= 1'b0;
    wait_cyc(8);
    wr_reg(hpc_pkg::OFF_IC, 32'hf);
    // hibernate with wake on match zero, wake flags set beforehand
    wr_reg(hpc_pkg::OFF_MATCH0, 32'h3);
    rd_chk(hpc_pkg::OFF_MATCH0, 32'h3);
    wr_reg(hpc_pkg::OFF_MATCH1, 32'h5);
    wr_reg(hpc_pkg::OFF_RTC, 32'h0);
    wr_reg(hpc_pkg::OFF_CTRL, 32'h13);
    wr_reg(hpc_pkg::OFF_CTRL, 32'h93);
    wait_cyc(2);
    check({31'h0, regulator_en}, 32'h0);
    check({31'h0, powered}, 32'h0);
    n = 0;
    while (regulator_en !== 1'b1 && n < 1000) begin
      @(posedge clock);
      n++;
    end
    #1;
    check({31'h0, regulator_en}, 32'h1);
    rd_chk(hpc_pkg::OFF_RTC, 32'h3);
    rd_chk(hpc_pkg::OFF_RIS, 32'h4);
    rd_chk(hpc_pkg::OFF_CTRL, 32'h13);
    wait_cyc(200);
    rd_chk(hpc_pkg::OFF_RIS, 32'hc);
    // stopped counter holds a loaded value
    wr_reg(hpc_pkg::OFF_CTRL, 32'h11);
    wr_reg(hpc_pkg::OFF_RTC, 32'h7);
    wait_cyc(200);
    rd_chk(hpc_pkg::OFF_RTC, 32'h7);
    // retained storage, last word, and write-only clear reads zero
    wr_reg(9'h1fc, 32'hc0de0a5a);
    rd_chk(9'h1fc, 32'hc0de0a5a);
    rd_chk(hpc_pkg::OFF_IC, 32'h0);
    // crystal source divided by 128: four ticks of 128 crystal edges make one count
    wr_reg(hpc_pkg::OFF_CTRL, 32'h07);
    wr_reg(hpc_pkg::OFF_RTC, 32'h0);
    wait_cyc(1800);
    rd_chk(hpc_pkg::OFF_RTC, 32'h0);
    wait_cyc(600);
    rd_chk(hpc_pkg::OFF_RTC, 32'h1);
    // hibernate with wake on the pin only, counter stopped
    wr_reg(hpc_pkg::OFF_IC, 32'hf);
    wr_reg(hpc_pkg::OFF_CTRL, 32'h89);
    wait_cyc(2);
    check({31'h0, regulator_en}, 32'h0);
    @(posedge clock);
    wake_lvl <= 1'b1;
    wait_cyc(8);
    check({31'h0, regulator_en}, 32'h1);
    rd_chk(hpc_pkg::OFF_RIS, 32'h1);
    rd_chk(hpc_pkg::OFF_CTRL, 32'h9);
    stop_test();
  end
endmodule
